// *** inc/dpw_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dpw_if (
    input wire logic pclk,
    input wire logic presetn
);
    import dpw_pkg::*;
    logic probe_cmd;
    logic [1:0] probe_en;
    logic [NEDGE-1:0] probe_edge;
    logic vel_sel;
    logic [1:0] win_mode;
    logic [DW-1:0] vel_cmd;
    logic [DW-1:0] vel_win;
    logic [PCT_W-1:0] vel_pct;
    logic [DW-1:0] sw_ctrl;
    logic [DW-1:0] sw_hyst;
    logic pt_wr;
    logic [4:0] pt_idx;
    logic [DW-1:0] pt_data;
    logic [1:0] cmd_stat;
    logic cmd_chg;
    logic [NEDGE-1:0] latched;
    logic [NEDGE-1:0][DW-1:0] cap_val;
    logic vel_match;
    logic class3_diagnostic;
    logic [NSW-1:0] sw_flag;
    modport drv (
        input probe_cmd, probe_en, probe_edge, vel_sel, win_mode, vel_cmd, vel_win, vel_pct,
        input sw_ctrl, sw_hyst, pt_wr, pt_idx, pt_data,
        output cmd_stat, cmd_chg, latched, cap_val, vel_match, class3_diagnostic, sw_flag
    );
    modport ctl (
        output probe_cmd, probe_en, probe_edge, vel_sel, win_mode, vel_cmd, vel_win, vel_pct,
        output sw_ctrl, sw_hyst, pt_wr, pt_idx, pt_data,
        input cmd_stat, cmd_chg, latched, cap_val, vel_match, class3_diagnostic, sw_flag
    );
endinterface
`default_nettype wire

// *** inc/dpw_pkg.sv ***
package dpw_pkg;
    // Data path widths
    localparam int DW = 32;
    localparam int NSW = 16;
    localparam int PCT_W = 16;
    localparam int PCT_FRAC = 16;
    localparam int IRQ_W = 6;
    // Edge slots: probe 1 rise, probe 1 fall, probe 2 rise, probe 2 fall
    localparam int NEDGE = 4;
    // Command acknowledge codes
    localparam logic [1:0] CST_NONE = 2'h0;
    localparam logic [1:0] CST_SET_EN = 2'h3;
    // APB register offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_SWCTL = 12'h004;
    localparam logic [11:0] REG_HYST = 12'h008;
    localparam logic [11:0] REG_VCMD = 12'h00C;
    localparam logic [11:0] REG_VWIN = 12'h010;
    localparam logic [11:0] REG_VPCT = 12'h014;
    localparam logic [11:0] REG_STAT = 12'h018;
    localparam logic [11:0] REG_SWFLAG = 12'h01C;
    localparam logic [11:0] REG_CAP0 = 12'h020;
    localparam logic [11:0] REG_ISTAT = 12'h030;
    localparam logic [11:0] REG_ICLR = 12'h034;
    localparam logic [11:0] REG_IEN = 12'h038;
    localparam logic [11:0] REG_PT_BASE = 12'h100;
    // Control register fields
    localparam int CTL_CMD = 0;
    localparam int CTL_EN = 1;
    localparam int CTL_EDGE = 4;
    localparam int CTL_VSEL = 8;
    localparam int CTL_WMODE = 9;
    localparam logic [31:0] CTRL_RST = 32'h0000_0600;
    localparam logic [31:0] SWCTL_RST = 32'h0000_0000;
    // Status register fields
    localparam int ST_CST = 0;
    localparam int ST_CHG = 2;
    localparam int ST_LAT = 4;
    localparam int ST_VM = 8;
    localparam int ST_DIAG = 9;
    // Interrupt bits
    localparam int IRQ_CAP = 0;
    localparam int IRQ_VM = 4;
    localparam int IRQ_ERR = 5;
endpackage

// *** verif/dpw_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpw_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic probe_cmd,
    input wire logic [1:0] probe_en,
    input wire logic [dpw_pkg::NEDGE-1:0] probe_edge,
    input wire logic [dpw_pkg::DW-1:0] sw_ctrl,
    input wire logic [1:0] cmd_stat,
    input wire logic cmd_chg,
    input wire logic [dpw_pkg::NEDGE-1:0] latched,
    input wire logic [dpw_pkg::NEDGE-1:0][dpw_pkg::DW-1:0] cap_val,
    input wire logic vel_match,
    input wire logic class3_diagnostic,
    input wire logic [dpw_pkg::NSW-1:0] sw_flag
);
    import dpw_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Command handshake
    a_cmd_ack: assert property (1 |=>
        cmd_stat == ($past(probe_cmd) ? CST_SET_EN : CST_NONE))
        else $error("cmd_stat does not follow probe_cmd");
    a_chg_on_err: assert property ($rose(cmd_chg) |->
        $past(probe_cmd) && $past(probe_edge) == 4'h0)
        else $error("cmd_chg rose without error");
    // Capture status only for selected edges, held while armed
    a_edge_select: assert property (
        (latched & ~$past(latched) & ~$past(probe_edge)) == 4'h0)
        else $error("latched set for unselected edge");
    a_cmd_clears: assert property (!probe_cmd |=> latched == 4'h0)
        else $error("latched kept without command");
    a_en_rearm: assert property (!probe_en[0] |=> latched[1:0] == 2'h0)
        else $error("probe 1 lock not lifted");
    a_lock_hold: assert property (latched[0] && probe_cmd && probe_en[0] |=> latched[0])
        else $error("latched dropped while armed");
    a_cap_frozen: assert property (latched[0] && $past(latched[0]) |->
        $stable(cap_val[0]))
        else $error("locked capture overwritten");
    // Velocity status mirrored to diagnostic bit
    a_diag_mirror: assert property (vel_match == class3_diagnostic)
        else $error("diagnostic differs from vel_match");
    // Switch flags need their enable
    a_sw_off: assert property ((sw_ctrl[15:0] == 16'h0) [*8] |-> sw_flag == 16'h0)
        else $error("flag set with all switches off");
    a_flag_needs_en: assert property (
        (sw_flag & ~$past(sw_flag) & ~$past(sw_ctrl[15:0])) == 16'h0)
        else $error("disabled switch flag rose");
    c_cap: cover property ($rose(latched[0]));
    c_vm: cover property ($rose(vel_match));
    c_chg: cover property ($rose(cmd_chg));
    c_flag: cover property ($rose(sw_flag[1]));
endmodule // dpw_properties
`default_nettype wire

// *** verif/drive_probe_window_switches_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module drive_probe_window_switches_tb_top;
    import dpw_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, tick, err, s;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, c0, c1, c2, fb, wn;
    logic [1:0] pin, wm;
    logic [15:0] pc;
    logic [DW-1:0] pos, vf1, vf2;
    logic [NSW-1:0] mst, swo;
    int on_p [NSW];
    int off_p [NSW];
    int hp [8];
    int n_mismatch = 0;
    int checked = 0;
    int tc = 0;
    int ck, w, d, p;
    dpw_if lk (.pclk(pclk), .presetn(presetn));
    dpw_ctrl dpw_ctrl_inst (.pclk(pclk), .presetn(presetn), .lk(lk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    dpw_drive dpw_drive_inst (.pclk(pclk), .presetn(presetn), .lk(lk), .sample_tick(tick),
        .probe_pin(pin), .pos_fb(pos), .vel_fb1(vf1), .vel_fb2(vf2), .sw_flag_o(swo));
    dpw_properties dpw_properties_inst (.pclk(pclk), .presetn(presetn),
        .probe_cmd(lk.probe_cmd), .probe_en(lk.probe_en), .probe_edge(lk.probe_edge),
        .sw_ctrl(lk.sw_ctrl), .cmd_stat(lk.cmd_stat), .cmd_chg(lk.cmd_chg),
        .latched(lk.latched), .cap_val(lk.cap_val), .vel_match(lk.vel_match),
        .class3_diagnostic(lk.class3_diagnostic), .sw_flag(lk.sw_flag));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Sample tick every fourth cycle
    always @(posedge pclk) begin
        tc <= tc + 1;
        tick <= (tc % 4 == 3);
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic vexp(int dd, int ww);
        return (dd < 0 ? -dd : dd) <= ww;
    endfunction
    // Switch flag model with hysteresis on both points
    function automatic logic nxt(logic cur, logic en, logic cam, int q, int on, int off, int h);
        if (!en) return 1'b0;
        // On above off: window wraps across the modulo seam
        if (cam && on > off) begin
            return cur ? (q >= on - h || q < off + h) : (q >= on || q < off);
        end
        if (cur) return q >= on - h && (!cam || q < off + h);
        return q >= on && (!cam || q < off);
    endfunction
    task automatic print_verdict();
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // Idle edge first, so release and next setup never collide
    task automatic apb(logic wr_, logic [11:0] a, logic [31:0] dt);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_;
        paddr <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] dt);
        apb(1'b1, a, dt);
    endtask
    task automatic rdc(string nm, logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // New position, then a pin level held past two ticks
    task automatic pinp(int i, logic v, output logic [31:0] q);
        q = rnd();
        pos <= q;
        @(posedge pclk);
        pin[i] <= v;
        repeat (10) @(posedge pclk);
    endtask
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pin = 2'h0;
        pos = 32'h0;
        vf1 = 32'h5;
        vf2 = 32'h0;
        seed = 32'h0000_54EA;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl", REG_CTRL, CTRL_RST);
        rdc("swctl", REG_SWCTL, SWCTL_RST);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        // No edge selected: error report, interrupt masked then raised and cleared
        wr(REG_CTRL, 32'h1);
        repeat (3) @(posedge pclk);
        rdc("stat_err", REG_STAT, 32'h7);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(REG_IEN, 32'h20);
        repeat (2) @(posedge pclk);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr(REG_ICLR, 32'h20);
        repeat (2) @(posedge pclk);
        chk("irq_off", 32'h0, {31'h0, irq});
        // Probe 2 falling edge left unselected
        wr(REG_CTRL, 32'h0);
        wr(REG_CTRL, 32'h677);
        pinp(0, 1'b1, c0);
        pinp(0, 1'b0, c1);
        pinp(0, 1'b1, c2);
        pinp(1, 1'b1, c2);
        pinp(1, 1'b0, fb);
        rdc("stat_lat", REG_STAT, 32'h73);
        rdc("cap0", REG_CAP0, c0);
        rdc("cap1", REG_CAP0 + 12'h4, c1);
        rdc("cap2", REG_CAP0 + 12'h8, c2);
        rdc("cap3", REG_CAP0 + 12'hC, 32'h0);
        rdc("istat", REG_ISTAT, 32'h7);
        wr(REG_CTRL, 32'h675);
        wr(REG_CTRL, 32'h677);
        pinp(0, 1'b0, c1);
        pinp(0, 1'b1, c0);
        rdc("cap0_rearm", REG_CAP0, c0);
        rdc("cap1_rearm", REG_CAP0 + 12'h4, c1);
        // Velocity window near its edge; unselected feedback far off
        for (int k = 0; k < 24; k++) begin
            ck = int'(rnd() % 128) - 64;
            pc = 16'(rnd() % 1024);
            wn = rnd() % 4096;
            wm = 2'(1 + rnd() % 3);
            s = rnd() > 32'h7FFF_FFFF;
            w = (wm[1] ? (ck < 0 ? -ck : ck) * int'(pc) : 0) + (wm[0] ? int'(wn) : 0);
            d = (w + int'(rnd() % 3) - 1) * (k % 2 ? -1 : 1);
            fb = 32'((ck << 16) + d);
            wr(REG_VCMD, 32'(ck << 16));
            wr(REG_VWIN, wn);
            wr(REG_VPCT, {16'h0, pc});
            wr(REG_CTRL, {21'h0, wm, s, 8'h0});
            vf1 <= s ? ~fb : fb;
            vf2 <= s ? fb : ~fb;
            repeat (10) @(posedge pclk);
            rdc("vel", REG_STAT, {22'h0, {2{vexp(d, w)}}, 8'h0});
        end
        // Odd switches in cam mode, the last one disabled
        pos <= 32'h0;
        for (int i = 0; i < NSW; i++) begin
            on_p[i] = 100 + i * 100 + int'(rnd() % 50);
            off_p[i] = on_p[i] + 200 + int'(rnd() % 100);
            // Switch 13 gets a cam window across the modulo seam
            if (i == 13) begin
                {on_p[i], off_p[i]} = {off_p[i], on_p[i]};
            end
            wr(REG_PT_BASE + 12'(4 * i), 32'(on_p[i]));
            wr(REG_PT_BASE + 12'(4 * (i + 16)), 32'(off_p[i]));
        end
        wr(REG_HYST, 32'h1E);
        wr(REG_SWCTL, 32'hAAAA_7FFF);
        // Let a tick settle the flags at position 0 first
        repeat (10) @(posedge pclk);
        for (int i = 0; i < NSW; i++) begin
            mst[i] = nxt(1'b0, i != 15, i % 2 == 1, 0, on_p[i], off_p[i], 30);
        end
        hp = '{on_p[1] - 1, on_p[1], on_p[1] - 30, on_p[1] - 31, on_p[1], off_p[1] + 29,
            off_p[1] + 30, off_p[1] - 1};
        for (int k = 0; k < 40; k++) begin
            p = k < 8 ? hp[k] : int'(rnd() % 1900);
            pos <= 32'(p);
            repeat (10) @(posedge pclk);
            for (int i = 0; i < NSW; i++) begin
                mst[i] = nxt(mst[i], i != 15, i % 2 == 1, p, on_p[i], off_p[i], 30);
            end
            rdc("swflag", REG_SWFLAG, {16'h0, mst});
            chk("sw_flag_o", {16'h0, mst}, {16'h0, swo});
        end
        print_verdict();
    end
endmodule // drive_probe_window_switches_tb_top
`default_nettype wire

// *** verilog/dpw_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpw_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    dpw_if.ctl lk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import dpw_pkg::*;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] swctl;
        logic [31:0] hyst;
        logic [31:0] vcmd;
        logic [31:0] vwin;
        logic [PCT_W-1:0] vpct;
        logic [IRQ_W-1:0] istat;
        logic [IRQ_W-1:0] ien;
        logic [NEDGE-1:0] plat;
        logic pvm;
        logic pchg;
        logic [31:0] rdata;
        logic rdy;
        logic err;
        logic irq;
        logic pt_wr;
        logic [4:0] pt_idx;
        logic [31:0] pt_data;
    } dpw_ctl_st_t;

    dpw_ctl_st_t q;
    dpw_ctl_st_t d;

    // Address decode for the error answer; the read mux decodes on its own
    function automatic logic mapped(input logic [11:0] a);
        return (a[1:0] == 2'h0) && ((a <= REG_IEN) || (a[11:7] == REG_PT_BASE[11:7]));
    endfunction

    // Next state: APB slave, link drive, interrupt latch
    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        logic [31:0] st;
        ev = '0;
        clr = '0;
        st = '0;
        d = q;
        d.rdy = 1'b0;
        d.err = 1'b0;
        d.pt_wr = 1'b0;

        st[ST_CST +: 2] = lk.cmd_stat;
        st[ST_CHG] = lk.cmd_chg;
        st[ST_LAT +: NEDGE] = lk.latched;
        st[ST_VM] = lk.vel_match;
        st[ST_DIAG] = lk.class3_diagnostic;

        // Setup cycle: decode and load read data so access ends at once
        if (psel && !penable) begin
            d.rdy = 1'b1;
            d.err = !mapped(paddr);
            d.rdata = '0;
            case (paddr)
                REG_CTRL: d.rdata = q.ctrl;
                REG_SWCTL: d.rdata = q.swctl;
                REG_HYST: d.rdata = q.hyst;
                REG_VCMD: d.rdata = q.vcmd;
                REG_VWIN: d.rdata = q.vwin;
                REG_VPCT: d.rdata = {16'h0000, q.vpct};
                REG_STAT: d.rdata = st;
                REG_SWFLAG: d.rdata = {16'h0000, lk.sw_flag};
                REG_CAP0: d.rdata = lk.cap_val[0];
                REG_CAP0 + 12'h004: d.rdata = lk.cap_val[1];
                REG_CAP0 + 12'h008: d.rdata = lk.cap_val[2];
                REG_CAP0 + 12'h00C: d.rdata = lk.cap_val[3];
                REG_ISTAT: d.rdata = {26'h0, q.istat};
                REG_IEN: d.rdata = {26'h0, q.ien};
                default: d.rdata = '0;
            endcase
        end

        // Writes commit on the access edge only
        if (psel && penable && q.rdy && pwrite && !q.err) begin
            case (paddr)
                REG_CTRL: d.ctrl = pwdata;
                REG_SWCTL: d.swctl = pwdata;
                REG_HYST: d.hyst = pwdata;
                REG_VCMD: d.vcmd = pwdata;
                REG_VWIN: d.vwin = pwdata;
                REG_VPCT: d.vpct = pwdata[PCT_W-1:0];
                REG_ICLR: clr = pwdata[IRQ_W-1:0];
                REG_IEN: d.ien = pwdata[IRQ_W-1:0];
                default: begin
                    // Point window: forward one word to the drive
                    if (paddr[11:7] == REG_PT_BASE[11:7]) begin
                        d.pt_wr = 1'b1;
                        d.pt_idx = paddr[6:2];
                        d.pt_data = pwdata;
                    end
                end
            endcase
        end

        // Rising-edge events; a new event beats a same-cycle clear
        d.plat = lk.latched;
        d.pvm = lk.vel_match;
        d.pchg = lk.cmd_chg;
        ev[IRQ_CAP +: NEDGE] = lk.latched & ~q.plat;
        ev[IRQ_VM] = lk.vel_match && !q.pvm;
        ev[IRQ_ERR] = lk.cmd_chg && !q.pchg;
        d.istat = (q.istat & ~clr) | ev;
        d.irq = |(d.istat & d.ien);
    end

    // Single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.ctrl <= CTRL_RST;
            q.swctl <= SWCTL_RST;
        end else begin
            q <= d;
        end
    end

    // Bus and link outputs straight from state
    assign prdata = q.rdata;
    assign pready = q.rdy;
    assign pslverr = q.err;
    assign irq = q.irq;
    assign lk.probe_cmd = q.ctrl[CTL_CMD];
    assign lk.probe_en = q.ctrl[CTL_EN +: 2];
    assign lk.probe_edge = q.ctrl[CTL_EDGE +: NEDGE];
    assign lk.vel_sel = q.ctrl[CTL_VSEL];
    assign lk.win_mode = q.ctrl[CTL_WMODE +: 2];
    assign lk.vel_cmd = q.vcmd;
    assign lk.vel_win = q.vwin;
    assign lk.vel_pct = q.vpct;
    assign lk.sw_ctrl = q.swctl;
    assign lk.sw_hyst = q.hyst;
    assign lk.pt_wr = q.pt_wr;
    assign lk.pt_idx = q.pt_idx;
    assign lk.pt_data = q.pt_data;
endmodule // dpw_ctrl
`default_nettype wire

// *** verilog/dpw_drive.sv ***
// Behaviour
// RULE1 - Active command acknowledged, change bit only on error
// RULE2 - Edge select per probe; enable gates measuring
// RULE3 - Selected edge captures position, sets status bit
// RULE4 - Each latched bit separately visible to controller
// RULE5 - Captured edge locked against further occurrences
// RULE6 - Enable clear unlocks; next set re-arms
// RULE7 - Velocity match: error within percentage plus window
// RULE8 - Selectable feedback; fixed, percentage or both
// RULE9 - Match status as diagnostic and link bit
// RULE10 - Flag follows position versus on point
// RULE11 - One shared hysteresis for all on points
// RULE12 - Control bits 0-15 enable each switch
// RULE13 - Cam mode flag clears at off point
// RULE14 - Shared hysteresis also on off points
// RULE15 - Control bits 16-31 select cam mode
// RULE16 - Controller programs both points before cam use
// RULE17 - Cam mode handles modulo wrap of window
// RULE18 - All comparisons evaluated once per sample tick
// RULE19 - Flag releases only past point by hysteresis
`timescale 1ns/1ps
`default_nettype none
module dpw_drive #(
    parameter int unsigned N_SW = dpw_pkg::NSW
) (
    input wire logic pclk,
    input wire logic presetn,
    dpw_if.drv lk,
    input wire logic sample_tick,
    input wire logic [1:0] probe_pin,
    input wire logic [dpw_pkg::DW-1:0] pos_fb,
    input wire logic [dpw_pkg::DW-1:0] vel_fb1,
    input wire logic [dpw_pkg::DW-1:0] vel_fb2,
    output logic [dpw_pkg::NSW-1:0] sw_flag_o
);
    import dpw_pkg::*;

    // Point addressing and control word split assume exactly sixteen switches
    if (N_SW != NSW) begin : g_bad_nsw
        $error("dpw_drive: N_SW must equal 16");
    end

    typedef struct packed {
        logic [1:0] sy1;
        logic [1:0] sy2;
        logic [1:0] prev;
        logic [NEDGE-1:0] lat;
        logic [NEDGE-1:0][DW-1:0] cap;
        logic [1:0] cst;
        logic chg;
        logic vm;
        logic [NSW-1:0] flag;
        logic [NSW-1:0][DW-1:0] on_pt;
        logic [NSW-1:0][DW-1:0] off_pt;
    } dpw_drv_st_t;

    dpw_drv_st_t q;
    dpw_drv_st_t d;

    // Sign extension so that point minus hysteresis cannot wrap
    function automatic logic signed [DW:0] sx(input logic [DW-1:0] v);
        return $signed({v[DW-1], v});
    endfunction

    // Magnitude of a sign-extended value
    function automatic logic [DW:0] mag(input logic signed [DW:0] v);
        return v[DW] ? -v : v;
    endfunction

    // Next flag of one switch, strict to turn on, widened to stay on
    function automatic logic sw_next(
        input logic signed [DW:0] p,
        input logic signed [DW:0] on,
        input logic signed [DW:0] off,
        input logic signed [DW:0] h,
        input logic cam,
        input logic cur
    );
        logic s;
        logic l;
        if (!cam) begin
            s = (p >= on); // [RULE10]
            l = (p >= on - h); // [RULE11] [RULE19]
        end else if (on <= off) begin
            s = (p >= on) && (p < off); // [RULE13]
            l = (p >= on - h) && (p < off + h); // [RULE14]
        end else begin
            // Window crosses the modulo seam: on lies above off
            s = (p >= on) || (p < off); // [RULE17]
            l = (p >= on - h) || (p < off + h);
        end
        return cur ? l : s; // [RULE19]
    endfunction

    // Next state of all drive functions
    always_comb begin
        logic [DW-1:0] vfb;
        logic [DW:0] adiff;
        logic [DW:0] acmd;
        logic [DW+PCT_W-1:0] prod;
        logic [DW+1:0] lim;
        logic rise;
        logic fall;
        logic hit;
        logic err;
        int j;
        vfb = '0;
        adiff = '0;
        acmd = '0;
        prod = '0;
        lim = '0;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;
        err = 1'b0;
        j = 0;
        d = q;

        // Probe pins are asynchronous: two-stage synchroniser
        d.sy1 = probe_pin;
        d.sy2 = q.sy1;

        // Switch point writes from the controller
        if (lk.pt_wr) begin
            if (lk.pt_idx[4]) begin
                d.off_pt[lk.pt_idx[3:0]] = lk.pt_data;
            end else begin
                d.on_pt[lk.pt_idx[3:0]] = lk.pt_data;
            end
        end

        // Command with no edge selected cannot measure, so it is flagged
        err = lk.probe_cmd && (lk.probe_edge == '0);
        d.cst = lk.probe_cmd ? CST_SET_EN : CST_NONE; // [RULE1]
        d.chg = lk.probe_cmd && (q.chg || err); // [RULE1]

        // Probe edge capture with per-edge lockout
        for (int p = 0; p < 2; p++) begin
            rise = q.sy2[p] && !q.prev[p];
            fall = !q.sy2[p] && q.prev[p];
            if (!(lk.probe_cmd && lk.probe_en[p])) begin
                d.lat[2*p] = 1'b0; // [RULE6]
                d.lat[2*p+1] = 1'b0; // [RULE6]
            end else if (sample_tick) begin
                for (int e = 0; e < 2; e++) begin
                    j = 2 * p + e;
                    hit = (e == 0 ? rise : fall) && lk.probe_edge[j]; // [RULE2]
                    if (hit && !q.lat[j]) begin // [RULE5]
                        d.cap[j] = pos_fb; // [RULE3]
                        d.lat[j] = 1'b1; // [RULE3]
                    end
                end
            end
        end
        // Pulses shorter than a sample period may be missed
        if (sample_tick) begin
            d.prev = q.sy2; // [RULE18]
        end

        // Velocity window, evaluated on the sample tick
        vfb = lk.vel_sel ? vel_fb2 : vel_fb1; // [RULE8]
        adiff = mag(sx(vfb) - sx(lk.vel_cmd));
        acmd = mag(sx(lk.vel_cmd));
        prod = acmd[DW-1:0] * lk.vel_pct;
        if (lk.win_mode[1]) begin
            lim = {2'b00, prod[PCT_FRAC+DW-1:PCT_FRAC]}; // [RULE8]
        end
        if (lk.win_mode[0]) begin
            lim = lim + {2'b00, lk.vel_win}; // [RULE8]
        end
        if (sample_tick) begin
            d.vm = ({1'b0, adiff} <= lim); // [RULE7] [RULE18]
        end

        // Position and cam switches
        if (sample_tick) begin
            for (int i = 0; i < NSW; i++) begin
                if (!lk.sw_ctrl[i]) begin
                    d.flag[i] = 1'b0; // [RULE12]
                end else begin
                    d.flag[i] = sw_next(sx(pos_fb), sx(q.on_pt[i]), sx(q.off_pt[i]),
                        sx(lk.sw_hyst), lk.sw_ctrl[NSW+i], q.flag[i]); // [RULE15] [RULE18]
                end
            end
        end
    end

    // Single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Link outputs straight from state
    assign lk.cmd_stat = q.cst;
    assign lk.cmd_chg = q.chg;
    assign lk.latched = q.lat; // [RULE4]
    assign lk.cap_val = q.cap;
    assign lk.vel_match = q.vm;
    assign lk.class3_diagnostic = q.vm; // [RULE9]
    assign lk.sw_flag = q.flag;
    assign sw_flag_o = q.flag;
endmodule // dpw_drive
`default_nettype wire
